// ==== verilog/test_pattern_seed_config.sv ====
// register bank for frame-clock pattern, pseudo-random seed and input swap
// assumes an APB master on pclk; analog path consumes the swap outputs
`timescale 1ns/1ps
`include "tp_seed_consts.svh"
module test_pattern_seed_config (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ain_pos,
   input wire logic [7:0] ain_p,
   input wire logic [7:0] ain_n,
   output logic [7:0] conv_pos_ff,
   output logic [7:0] conv_neg_ff,
   output logic frame_clock_out_pos,
   output logic frame_clock_out_neg,
   output logic [22:0] lfsr_state,
   output logic random_active_ff
);
   tp_seed_pkg::reg16_t frame_reg_ff;
   tp_seed_pkg::reg16_t seed_low_ff;
   tp_seed_pkg::reg16_t seed_high_ff;
   tp_seed_pkg::reg16_t ctrl_ff;
   logic [3:0] frame_idx_ff;
   logic fclk_p_ff;
   logic fclk_n_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic load_ff;
   logic ain_pos_unused;
   tp_seed_pkg::seed_t nxt_seed;
   logic [22:0] lfsr_q;
   logic acc;
   logic wr;
   logic [7:0] idx;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic mapped(input logic [7:0] i);
      mapped = (i == `IDX_FRAME_PATTERN) || (i == `IDX_SEED_LOW) ||
               (i == `IDX_SEED_HIGH) || (i == `IDX_TP_CTRL);
   endfunction

   function automatic tp_seed_pkg::reg16_t merge(
      input tp_seed_pkg::reg16_t old, input logic [31:0] d,
      input logic [3:0] s, input tp_seed_pkg::reg16_t m);
      tp_seed_pkg::reg16_t n;
      n = old;
      if (s[0]) begin
         n[7:0] = d[7:0];
      end
      if (s[1]) begin
         n[15:8] = d[15:8];
      end
      merge = n & m;
   endfunction

   assign idx = paddr[9:2];
   assign acc = psel && penable && !pready_ff;
   assign wr = acc && pwrite && mapped(idx) && (paddr[1:0] == 2'h0);
   assign ain_pos_unused = ain_pos;

   ////////////////////////////////////////////////////////////////////////
   // one wait state: pready rises in the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
      end else begin
         pready_ff <= acc;
         pslverr_ff <= acc && !(mapped(idx) && paddr[1:0] == 2'h0);
         prdata_ff <= 32'h00000000;
         if (acc && !pwrite) begin
            case (idx)
               `IDX_FRAME_PATTERN: prdata_ff <= {16'h0000, frame_reg_ff};
               `IDX_SEED_LOW: prdata_ff <= {16'h0000, seed_low_ff};
               `IDX_SEED_HIGH: prdata_ff <= {16'h0000, seed_high_ff};
               // sync bit reads back as zero, it is an action not a state
               `IDX_TP_CTRL: prdata_ff <= {16'h0000, ctrl_ff};
               default: prdata_ff <= 32'h00000000;
            endcase
         end
      end
   end
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_reg_ff <= `RESET_VALUE;
         seed_low_ff <= `RESET_VALUE;
         seed_high_ff <= `RESET_VALUE;
         ctrl_ff <= `RESET_VALUE;
      end else if (wr) begin
         case (idx)
            `IDX_FRAME_PATTERN: frame_reg_ff <=
               merge(frame_reg_ff, pwdata, pstrb, `MASK_FRAME_PATTERN);
            `IDX_SEED_LOW: seed_low_ff <=
               merge(seed_low_ff, pwdata, pstrb, 16'hffff);
            // bit 8 forced low regardless of what software writes
            `IDX_SEED_HIGH: seed_high_ff <=
               merge(seed_high_ff, pwdata, pstrb, `MASK_SEED_HIGH);
            `IDX_TP_CTRL: ctrl_ff <=
               merge(ctrl_ff, pwdata, pstrb, `MASK_TP_CTRL);
            default: ctrl_ff <= ctrl_ff;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_seed = `DEFAULT_SEED;
      if (ctrl_ff[`BIT_SEED_SEL]) begin
         nxt_seed = {seed_high_ff[15:9], seed_low_ff};
      end
   end

   // reload on soft sync write, or when the pattern is off so it restarts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_ff <= 1'b1;
         random_active_ff <= 1'b0;
      end else begin
         load_ff <= !ctrl_ff[`BIT_RAND_EN] ||
            (wr && idx == `IDX_TP_CTRL && pstrb[1] &&
             pwdata[`BIT_SOFT_SYNC]);
         random_active_ff <= ctrl_ff[`BIT_RAND_EN];
      end
   end

   lfsr_gen u_lfsr (
      .pclk(pclk),
      .presetn(presetn),
      .load(load_ff),
      .enable(ctrl_ff[`BIT_RAND_EN]),
      .seed(nxt_seed),
      .state(lfsr_q)
   );
   assign lfsr_state = lfsr_q;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_idx_ff <= 4'h0;
         fclk_p_ff <= 1'b0;
         fclk_n_ff <= 1'b1;
      end else begin
         frame_idx_ff <= (frame_idx_ff == 4'hb) ? 4'h0 : frame_idx_ff + 4'h1;
         if (frame_reg_ff[`BIT_FRAME_EN]) begin
            fclk_p_ff <= frame_reg_ff[4'hb - frame_idx_ff];
            fclk_n_ff <= !frame_reg_ff[4'hb - frame_idx_ff];
         end else begin
            // stand-in frame clock: high for the first half of each frame
            fclk_p_ff <= frame_idx_ff < 4'h6;
            fclk_n_ff <= !(frame_idx_ff < 4'h6);
         end
      end
   end
   assign frame_clock_out_pos = fclk_p_ff;
   assign frame_clock_out_neg = fclk_n_ff;

   ////////////////////////////////////////////////////////////////////////
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_swap
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               conv_pos_ff[g] <= 1'b0;
               conv_neg_ff[g] <= 1'b0;
            end else begin
               conv_pos_ff[g] <= seed_high_ff[g] ? ain_n[g] : ain_p[g];
               conv_neg_ff[g] <= seed_high_ff[g] ? ain_p[g] : ain_n[g];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // one edge late: the first edge after power-up still shows unknowns
   AST_SEED_LOW_RESET: assert property (@(posedge pclk)
      !presetn |=> seed_low_ff == 16'h0000)
      else $error("seed low not cleared");
   AST_SEED_LOW_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      wr && idx == 8'h23 && pstrb == 4'hf |=>
      seed_low_ff == $past(pwdata[15:0]))
      else $error("seed low write lost");
   AST_BIT8_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      seed_high_ff[8] == 1'b0)
      else $error("seed high bit 8 set");
   AST_SEED_CONCAT: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_ff[14] |-> nxt_seed[22:16] == seed_high_ff[15:9] &&
      nxt_seed[15:0] == seed_low_ff)
      else $error("seed concat wrong");
   AST_DEFAULT_SEED: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_ff[14] |-> nxt_seed == 23'h7fffff)
      else $error("default seed not used");
   AST_LOAD_SEED: assert property (@(posedge pclk) disable iff (!presetn)
      load_ff |=> lfsr_q == $past(nxt_seed))
      else $error("generator not seeded");
   AST_RAND_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_ff[12] |=> !random_active_ff && load_ff)
      else $error("pattern not disabled");
   sequence soft_sync_wr;
      wr && idx == 8'h25 && pstrb[1] && pwdata[8];
   endsequence
   AST_SOFT_SYNC: assert property (@(posedge pclk) disable iff (!presetn)
      soft_sync_wr |=> load_ff ##1 lfsr_q == $past(nxt_seed))
      else $error("soft sync ignored");
   AST_SWAP: assert property (@(posedge pclk) disable iff (!presetn)
      seed_high_ff[0] |=> conv_pos_ff[0] == $past(ain_n[0]))
      else $error("swap not applied");
   AST_FRAME_PAT: assert property (@(posedge pclk) disable iff (!presetn)
      frame_reg_ff[14] |=> fclk_p_ff ==
      $past(frame_reg_ff[4'hb - frame_idx_ff]))
      else $error("frame pattern wrong");
endmodule

// ==== shared/tp_seed_consts.svh ====
// register offsets, field positions, reset values for the test-pattern seed
// configuration block; included by the design files
// Function
// - a 12-bit programmable field repeats onto the frame-clock output pair.
// - pattern replaces frame clock only while its enable bit is set.
// - seed low 16 bits sit in bits 15:0 of register 0x23.
// - the programmed seed is the generator's starting state.
// - seed upper seven bits in 15:9 of 0x24; bit 8 written zero.
// - programmed seed loads only when seed-source select set, else default.
// - seed-low register clears to zero on reset.
// - eight per-channel polarity-swap bits in bits 7:0.
// - a set swap bit exchanges a channel's positive and negative inputs.
// - pseudo-random pattern runs only while its enable bit is one.
// - writing the software sync bit restarts the single generator from its seed.
`ifndef TP_SEED_CONSTS_SVH
`define TP_SEED_CONSTS_SVH
// printed offsets are indexes; byte address is four times the index
`define IDX_FRAME_PATTERN 8'h1c
`define IDX_SEED_LOW 8'h23
`define IDX_SEED_HIGH 8'h24
`define IDX_TP_CTRL 8'h25
`define BIT_FRAME_EN 14
`define BIT_EXT_SYNC 15
`define BIT_SEED_SEL 14
`define BIT_LEN_SEL 13
`define BIT_RAND_EN 12
`define BIT_SOFT_SYNC 8
`define MASK_FRAME_PATTERN 16'h4fff
`define MASK_SEED_HIGH 16'hfeff
`define MASK_TP_CTRL 16'hf07f
`define RESET_VALUE 16'h0000
`define DEFAULT_SEED 23'h7fffff
`define LFSR_TAP_A 22
`define LFSR_TAP_B 17
`endif

// ==== shared/tp_seed_pkg.sv ====
// types shared by the test-pattern configuration block
package tp_seed_pkg;
   typedef logic [15:0] reg16_t;
   typedef logic [22:0] seed_t;
   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_ACCESS} apb_state_t;
endpackage

// ==== verilog/lfsr_gen.sv ====
// 23-bit pseudo-random generator with synchronous load
// assumes load and enable arrive as single-clock levels from the config block
`timescale 1ns/1ps
`include "tp_seed_consts.svh"
module lfsr_gen (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic enable,
   input wire tp_seed_pkg::seed_t seed,
   output logic [22:0] state
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= 23'h000000;
      end else if (load) begin
         state <= seed;
      end else if (enable) begin
         // all-zero state would lock up; restart from the default instead
         if (state == 23'h000000) begin
            state <= `DEFAULT_SEED;
         end else begin
            state <= {state[21:0],
               state[`LFSR_TAP_A] ^ state[`LFSR_TAP_B]};
         end
      end
   end
endmodule

// ==== bench/tb.sv ====
// self-checking bench for the test-pattern seed configuration block
// assumes a one-wait-state apb slave, byte address four times the index
`timescale 1ns/1ps
module tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rnd = 32'hdae9e9f0;
   logic [3:0] pstrb = 4'hf;
   logic [7:0] ain_p = 8'h00, ain_n = 8'h00, conv_pos_ff, conv_neg_ff, sw;
   logic frame_clock_out_pos, frame_clock_out_neg, pready, pslverr;
   logic random_active_ff, hit;
   logic [22:0] lfsr_state, sd;
   logic [23:0] b;
   logic [11:0] pat;
   logic [33:0] ev;
   logic [33:0] q[$];
   logic [11:0] ad[4] = '{12'h070, 12'h08c, 12'h090, 12'h094};
   int n_mismatch = 0, comparisons = 0;
   always #25 pclk = ~pclk;
   test_pattern_seed_config dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ain_pos(1'b0), .ain_p(ain_p), .ain_n(ain_n),
      .conv_pos_ff(conv_pos_ff), .conv_neg_ff(conv_neg_ff),
      .frame_clock_out_pos(frame_clock_out_pos),
      .frame_clock_out_neg(frame_clock_out_neg), .lfsr_state(lfsr_state),
      .random_active_ff(random_active_ff));
////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] nxt(input logic [31:0] x);
      return x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask
   task automatic close_out;
      if (q.size() != 0) n_mismatch++;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // e = {check data, expect error, data}
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d, input logic [3:0] s, input logic [33:0] e);
      int n;
      n = 0;
      q.push_back(e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 20) n_mismatch++;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so the next setup never lands in the release step
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] v);
      apb(1'b0, a, 32'h0, 4'hf, {2'b10, v});
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf, 34'h0);
   endtask
   task automatic grab;
      repeat (24) begin
         @(negedge pclk);
         b = {b[22:0], frame_clock_out_pos};
         chk("frame_neg", {31'h0, ~frame_clock_out_pos},
            {31'h0, frame_clock_out_neg});
      end
      @(posedge pclk);
   endtask
   always @(posedge pclk) begin
      if (pready === 1'b1) begin
         ev = q.size() != 0 ? q.pop_front() : 34'h3ffffffff;
         chk("pslverr", {31'h0, ev[32]}, {31'h0, pslverr});
         if (ev[33]) chk("prdata", ev[31:0], prdata);
      end
   end
   initial begin
      repeat (5000) @(posedge pclk);
      n_mismatch++;
      close_out();
   end
////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (ad[i]) rd(ad[i], 32'h0);
      $display("reset values done");
      rnd = nxt(rnd);
      wr(12'h08c, rnd);
      rd(12'h08c, {16'h0, rnd[15:0]});
      apb(1'b1, 12'h08c, 32'h0000ab00, 4'h2, 34'h0);
      rd(12'h08c, {16'h0, 8'hab, rnd[7:0]});
      wr(12'h090, 32'h0000ffff);
      rd(12'h090, 32'h0000feff);
      apb(1'b0, 12'h100, 32'h0, 4'hf, {2'b11, 32'h0});
      apb(1'b1, 12'h08e, 32'h0, 4'hf, {2'b01, 32'h0});
      rd(12'h08c, {16'h0, 8'hab, rnd[7:0]});
      wr(12'h094, 32'h0000f6ff);
      rd(12'h094, 32'h0000f07f);
      $display("register access done");
      for (int i = 0; i < 4; i++) begin
         rnd = nxt(rnd);
         sw = rnd[7:0];
         wr(12'h090, {16'h0, rnd[15:9], 1'b0, sw});
         ain_p <= rnd[23:16];
         ain_n <= rnd[31:24];
         @(posedge pclk);
         @(negedge pclk);
         chk("conv_pos", {24'h0, ain_p & ~sw | ain_n & sw},
            {24'h0, conv_pos_ff});
         chk("conv_neg", {24'h0, ain_n & ~sw | ain_p & sw},
            {24'h0, conv_neg_ff});
         @(posedge pclk);
      end
      $display("polarity swap done");
      pat = {1'b1, rnd[10:1], 1'b0};
      wr(12'h070, {20'h00004, pat});
      rd(12'h070, {20'h00004, pat});
      grab();
      hit = 1'b0;
      for (int r = 0; r < 12; r++) if (b[r+:12] === pat) hit = 1'b1;
      chk("frame_pat", 32'h1, {31'h0, hit});
      chk("frame_period", {20'h0, b[23:12]}, {20'h0, b[11:0]});
      wr(12'h070, {20'h0, pat});
      grab();
      chk("frame_ones", 32'h0000000c, 32'($countones(b)));
      $display("frame pattern done");
      rnd = nxt(rnd);
      sd = {rnd[31:25], rnd[15:0]};
      wr(12'h08c, {16'h0, rnd[15:0]});
      wr(12'h090, {16'h0, rnd[31:25], 9'h0});
      wr(12'h094, 32'h00004000);
      @(negedge pclk);
      chk("seed_load", {9'h0, sd}, {9'h0, lfsr_state});
      chk("rand_off", 32'h0, {31'h0, random_active_ff});
      @(posedge pclk);
      wr(12'h094, 32'h0);
      @(negedge pclk);
      chk("seed_dflt", 32'h007fffff, {9'h0, lfsr_state});
      @(posedge pclk);
      wr(12'h094, 32'h00005000);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk("rand_on", 32'h1, {31'h0, random_active_ff});
      chk("running", 32'h1, {31'h0, lfsr_state !== sd});
      @(posedge pclk);
      hit = 1'b0;
      fork
         wr(12'h094, 32'h00005100);
         repeat (5) begin
            @(negedge pclk);
            if (lfsr_state === sd) hit = 1'b1;
         end
      join
      chk("soft_sync", 32'h1, {31'h0, hit});
      @(posedge pclk);
      $display("generator done");
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(12'h08c, 32'h0);
      chk("rand_rst", 32'h0, {31'h0, random_active_ff});
      $display("second reset done");
      close_out();
   end
endmodule
